// *** verilog/iex_defs.svh ***
// Offsets, field positions, vector numbers and reset values of the exception sequencer
`ifndef IEX_DEFS_SVH
`define IEX_DEFS_SVH
// =====================================================================
// Register map (byte addresses)
`define IEX_OFF_CTRL 8'h00
`define IEX_OFF_STATUS 8'h04
`define IEX_OFF_COUNT 8'h08
`define IEX_CTRL_RST 2'h1
// =====================================================================
// Flags word bit positions
`define IEX_FLAG_IF 9
`define IEX_FLAG_OF 11
// =====================================================================
// Vector numbers
`define IEX_VEC_BRKPT 8'h03
`define IEX_VEC_OVFL 8'h04
`define IEX_VEC_RANGE 8'h05
`define IEX_VEC_PREDEF_LO 8'h08
`define IEX_VEC_DBL_FAULT 8'h08
`define IEX_VEC_BAD_TASK 8'h0a
`define IEX_VEC_PAGE_FAULT 8'h0e
`define IEX_VEC_FPERR 8'h10
`define IEX_VEC_ALIGN 8'h11
`define IEX_VEC_SIMDFP 8'h13
`define IEX_VEC_USER 8'h20
// =====================================================================
// Stack slot sizes in bytes and frame lengths in slots
`define IEX_BYTES_REAL 64'h2
`define IEX_BYTES_PROT 64'h4
`define IEX_BYTES_LONG 64'h8
`define IEX_POP_SHORT 3'h3
`define IEX_POP_LONG 3'h5
`endif

// *** verilog/iex_pkg.sv ***
// Types shared by the exception sequencer and its vector decoder
package iex_pkg;
    // =================================================================
    // Enumerations
    typedef enum logic [2:0] {
        IEX_OP_EVENT, IEX_OP_INTN, IEX_OP_INTO, IEX_OP_INT3,
        IEX_OP_BOUND, IEX_OP_FP, IEX_OP_INTR_RETURN_OP
    } iex_op_e;
    typedef enum logic [1:0] {IEX_MODE_REAL, IEX_MODE_PROT, IEX_MODE_LONG} iex_mode_e;
    typedef enum logic [1:0] {IEX_GATE_INTR, IEX_GATE_TRAP, IEX_GATE_TASK} iex_gate_e;
    typedef enum logic [2:0] {
        IEX_IDLE, IEX_LOOKUP, IEX_PUSH, IEX_ENTER, IEX_TASK, IEX_POP, IEX_DONE
    } iex_state_e;
    // =================================================================
    // Carriers
    typedef struct packed {
        iex_op_e op;
        logic [7:0] vector;
        logic [31:0] err_code;
        logic bound_out;
        logic [5:0] fp_cond;
        logic fp_simd;
    } iex_req_s;
    typedef struct packed {
        logic [31:0] flags_word;
        logic [15:0] cs;
        logic [63:0] instr_pointer;
        logic [15:0] ss;
        logic [63:0] wide_stack_pointer;
        logic [1:0] current_priv_level;
    } iex_arch_s;
    typedef struct packed {
        iex_gate_e kind;
        logic [15:0] cs;
        logic [63:0] ip;
        logic [1:0] dpl;
        logic [15:0] tss_ss;
        logic [63:0] tss_sp;
    } iex_gate_s;
    typedef struct packed {
        iex_state_e st;
        iex_mode_e mode;
        logic [7:0] vec;
        logic err;
        logic [31:0] ecode;
        iex_arch_s arch;
        iex_gate_s gate;
        logic sw;
        logic [5:0][63:0] fr;
        logic [2:0] n;
        logic [2:0] idx;
        logic [63:0] maddr;
        logic [63:0] mdata;
        logic fault;
        logic ack;
        logic [31:0] rdata;
        logic [31:0] cnt;
    } iex_state_s;
endpackage : iex_pkg

// *** verilog/iex_vec_decode.sv ***
// Decoder from a pipeline request to the vector it dispatches
`include "iex_defs.svh"
module iex_vec_decode (
    // Request
    input wire iex_pkg::iex_req_s i_req,
    input wire logic i_overflow_flag,
    // Decision
    output logic o_fire,
    output logic [7:0] o_vector,
    output logic o_has_err
);
    // =================================================================
    // Error-code lookup
    function automatic logic err_lookup(input logic [7:0] v);
        err_lookup = (v == `IEX_VEC_DBL_FAULT) || (v == `IEX_VEC_ALIGN)
            || (v >= `IEX_VEC_BAD_TASK && v <= `IEX_VEC_PAGE_FAULT);
    endfunction : err_lookup

    // =================================================================
    // Dispatch decision per operation
    always_comb begin
        o_fire = 1'b1;
        o_vector = i_req.vector;
        o_has_err = 1'b0;
        case (i_req.op)
            iex_pkg::IEX_OP_EVENT: begin
                o_has_err = err_lookup(i_req.vector); // [RL25]
            end
            iex_pkg::IEX_OP_INTN: begin
                o_fire = 1'b1; // Any vector, same path as an event [RL16]
            end
            iex_pkg::IEX_OP_INTO: begin
                o_fire = i_overflow_flag; // [RL17]
                o_vector = `IEX_VEC_OVFL;
            end
            iex_pkg::IEX_OP_INT3: begin
                o_vector = `IEX_VEC_BRKPT; // [RL18]
            end
            iex_pkg::IEX_OP_BOUND: begin
                o_fire = i_req.bound_out; // [RL19]
                o_vector = `IEX_VEC_RANGE;
            end
            iex_pkg::IEX_OP_FP: begin
                o_fire = |i_req.fp_cond; // [RL20]
                o_vector = i_req.fp_simd ? `IEX_VEC_SIMDFP : `IEX_VEC_FPERR;
            end
            default: begin
                o_fire = 1'b0;
            end
        endcase
    end
endmodule : iex_vec_decode

// *** verilog/iex_exc_seq.sv ***
// Exception entry and return sequencer with its Avalon-MM register slave
//
// What this block does
// [RL1] Same-level handler keeps current stack; more privileged handler switches stack.
// [RL2] Without switch push flags word, code selector, then instruction pointer.
// [RL3] Without switch push error code after instruction pointer when vector has one.
// [RL4] After pushes load code selector and pointer from gate, then run handler.
// [RL5] Interrupt gate entry clears interrupt enable before handler starts.
// [RL6] Switching entry first holds old stack, flags, code selector, pointer.
// [RL7] Switching entry takes new stack pointer from task state block, and the selector too outside 64-bit mode.
// [RL8] Then push held stack selector, pointer, flags, code selector, pointer in order.
// [RL9] Switching entry pushes error code after the five saved values.
// [RL10] Interrupt return also reloads the flags word.
// [RL11] Same-level return restores selector, pointer, flags, pops frame, resumes.
// [RL12] Cross-level return checks privilege in protected mode only, restores, then reloads old stack.
// [RL13] Task gate triggers a full task switch that saves and restores state.
// [RL14] Real mode indexes a pointer table by vector and far-calls the entry.
// [RL15] Real mode pushes flags, selector, pointer, error code; returns by interrupt return.
// [RL16] Software vector call dispatches any vector like a hardware event.
// [RL17] Overflow trap raises vector 4 only when overflow flag is set.
// [RL18] Breakpoint operation always dispatches to the breakpoint handler.
// [RL19] Range check raises vector 5 when operand is out of bounds; never implicit.
// [RL20] Six fp conditions: legacy unit gives fp error, packed SIMD gives SIMD fp.
// [RL21] In 64-bit mode every push is an 8-byte zero-extended slot.
// [RL22] 64-bit mode always pushes stack; new stack selector null on level change.
// [RL23] Vectors 32 to 255 are maskable user interrupts; lower ones predefined.
// [RL24] Trap gate entry leaves interrupt enable unchanged.
// [RL25] A fixed per-vector lookup decides whether an error code is pushed.
`include "iex_defs.svh"
module iex_exc_seq #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Pipeline request and result
    input wire logic i_req_valid,
    input wire iex_pkg::iex_req_s i_req,
    input wire iex_pkg::iex_arch_s i_arch,
    output logic o_req_ready,
    output logic o_done,
    output logic o_fault,
    output iex_pkg::iex_arch_s o_arch,
    // Descriptor table lookup
    output logic o_tbl_valid,
    output logic [7:0] o_tbl_vector,
    output logic o_tbl_real,
    input wire logic i_tbl_ready,
    input wire iex_pkg::iex_gate_s i_gate,
    // Task switch unit
    output logic o_task_valid,
    output logic [7:0] o_task_vector,
    input wire logic i_task_done,
    // Stack memory
    output logic o_mem_valid,
    output logic o_mem_write,
    output logic [63:0] o_mem_addr,
    output logic [63:0] o_mem_wdata,
    input wire logic i_mem_ready,
    input wire logic [63:0] i_mem_rdata
);
    // =================================================================
    // Helpers
    function automatic logic [63:0] slot_bytes(input iex_pkg::iex_mode_e m);
        case (m)
            iex_pkg::IEX_MODE_REAL: slot_bytes = `IEX_BYTES_REAL;
            iex_pkg::IEX_MODE_LONG: slot_bytes = `IEX_BYTES_LONG; // [RL21]
            default: slot_bytes = `IEX_BYTES_PROT;
        endcase
    endfunction : slot_bytes

    // Zero-extend to the slot width of the mode
    function automatic logic [63:0] fit(input iex_pkg::iex_mode_e m, input logic [63:0] v);
        case (m)
            iex_pkg::IEX_MODE_REAL: fit = {48'h0, v[15:0]};
            iex_pkg::IEX_MODE_LONG: fit = v; // [RL21]
            default: fit = {32'h0, v[31:0]};
        endcase
    endfunction : fit

    // =================================================================
    // Decoder
    logic dec_fire;
    logic [7:0] dec_vec;
    logic dec_err;

    iex_vec_decode u_dec (
        .i_req(i_req),
        .i_overflow_flag(i_arch.flags_word[`IEX_FLAG_OF]),
        .o_fire(dec_fire),
        .o_vector(dec_vec),
        .o_has_err(dec_err)
    );

    // =================================================================
    // State
    iex_pkg::iex_state_s s;
    iex_pkg::iex_state_s next_s;
    logic [63:0] w;
    logic bus_req;
    logic push_ss;
    logic [2:0] k;
    logic [63:0] v;
    logic [1:0] rpl;

    assign w = slot_bytes(s.mode);
    assign bus_req = i_avs_read | i_avs_write;

    // Next-state logic for bus slave and sequencer
    always_comb begin
        next_s = s;
        push_ss = 1'b0;
        k = 3'h0;
        v = fit(s.mode, i_mem_rdata);
        rpl = s.fr[1][1:0];
        // One wait state: data latched on the request cycle, answered on the next
        next_s.ack = bus_req & ~s.ack;
        if (bus_req && !s.ack) begin
            case (i_avs_address)
                `IEX_OFF_CTRL: next_s.rdata = {30'h0, s.mode};
                `IEX_OFF_STATUS: next_s.rdata = {16'h0, s.vec, 5'h0,
                    (s.vec >= `IEX_VEC_USER), s.fault, (s.st != iex_pkg::IEX_IDLE)}; // [RL23]
                `IEX_OFF_COUNT: next_s.rdata = s.cnt;
                default: next_s.rdata = 32'h0;
            endcase
        end
        if (s.ack && i_avs_write && i_avs_address == `IEX_OFF_CTRL) begin
            next_s.mode = iex_pkg::iex_mode_e'(i_avs_writedata[1:0]);
        end
        case (s.st)
            iex_pkg::IEX_IDLE: begin
                if (i_req_valid) begin
                    next_s.arch = i_arch;
                    next_s.vec = dec_vec;
                    next_s.err = dec_err;
                    next_s.ecode = i_req.err_code;
                    next_s.fault = 1'b0;
                    next_s.idx = 3'h0;
                    next_s.sw = 1'b0;
                    if (i_req.op == iex_pkg::IEX_OP_INTR_RETURN_OP) begin
                        next_s.n = `IEX_POP_SHORT; // [RL10]
                        next_s.maddr = i_arch.wide_stack_pointer;
                        next_s.st = iex_pkg::IEX_POP;
                    end else if (dec_fire) begin
                        next_s.st = iex_pkg::IEX_LOOKUP; // [RL16]
                    end else begin
                        next_s.st = iex_pkg::IEX_DONE; // Nothing raised [RL17] [RL19]
                    end
                end
            end
            iex_pkg::IEX_LOOKUP: begin
                if (i_tbl_ready) begin
                    next_s.gate = i_gate;
                    next_s.cnt = s.cnt + 32'h1;
                    if (s.mode != iex_pkg::IEX_MODE_REAL
                        && i_gate.kind == iex_pkg::IEX_GATE_TASK) begin
                        next_s.st = iex_pkg::IEX_TASK; // [RL13]
                    end else begin
                        // Old state is held in the frame slots before any change [RL6]
                        if (s.mode != iex_pkg::IEX_MODE_REAL) begin
                            next_s.sw = i_gate.dpl < s.arch.current_priv_level; // [RL1]
                        end
                        push_ss = next_s.sw || s.mode == iex_pkg::IEX_MODE_LONG; // [RL22]
                        if (push_ss) begin
                            next_s.fr[0] = {48'h0, s.arch.ss}; // [RL8]
                            next_s.fr[1] = s.arch.wide_stack_pointer;
                            k = 3'h2;
                        end
                        next_s.fr[k] = {32'h0, s.arch.flags_word}; // [RL2] [RL15]
                        next_s.fr[k + 3'h1] = {48'h0, s.arch.cs};
                        next_s.fr[k + 3'h2] = s.arch.instr_pointer;
                        next_s.fr[k + 3'h3] = {32'h0, s.ecode}; // [RL3] [RL9]
                        next_s.n = k + 3'h3 + {2'h0, s.err};
                        if (next_s.sw) begin
                            // New level's stack from the task state block [RL7]
                            next_s.arch.wide_stack_pointer = i_gate.tss_sp;
                            next_s.arch.ss = (s.mode == iex_pkg::IEX_MODE_LONG)
                                ? 16'h0 : i_gate.tss_ss; // [RL22]
                        end
                        next_s.maddr = fit(s.mode, next_s.arch.wide_stack_pointer - w);
                        next_s.mdata = fit(s.mode, next_s.fr[0]);
                        next_s.st = iex_pkg::IEX_PUSH;
                    end
                end
            end
            iex_pkg::IEX_PUSH: begin
                if (i_mem_ready) begin
                    next_s.arch.wide_stack_pointer = s.maddr;
                    next_s.idx = s.idx + 3'h1;
                    next_s.maddr = fit(s.mode, s.maddr - w);
                    next_s.mdata = fit(s.mode, s.fr[s.idx + 3'h1]);
                    if (s.idx + 3'h1 == s.n) begin
                        next_s.st = iex_pkg::IEX_ENTER;
                    end
                end
            end
            iex_pkg::IEX_ENTER: begin
                // Real mode: gate fields hold the table entry [RL14]
                next_s.arch.cs = s.gate.cs; // [RL4]
                next_s.arch.instr_pointer = s.gate.ip;
                if (s.mode == iex_pkg::IEX_MODE_REAL || s.gate.kind == iex_pkg::IEX_GATE_INTR) begin
                    next_s.arch.flags_word[`IEX_FLAG_IF] = 1'b0; // [RL5] [RL24]
                end
                if (s.sw) begin
                    next_s.arch.current_priv_level = s.gate.dpl;
                end
                next_s.st = iex_pkg::IEX_DONE;
            end
            iex_pkg::IEX_TASK: begin
                // State save and restore belong to the task switch unit [RL13]
                if (i_task_done) begin
                    next_s.st = iex_pkg::IEX_DONE;
                end
            end
            iex_pkg::IEX_POP: begin
                if (i_mem_ready) begin
                    next_s.fr[s.idx] = v;
                    next_s.idx = s.idx + 3'h1;
                    next_s.maddr = fit(s.mode, s.maddr + w);
                    if (s.idx == 3'h1 && s.mode == iex_pkg::IEX_MODE_PROT
                        && v[1:0] < s.arch.current_priv_level) begin
                        next_s.fault = 1'b1; // Privilege check, frame left unused [RL12]
                        next_s.st = iex_pkg::IEX_DONE;
                    end
                    if (s.idx == 3'h2 && (s.mode == iex_pkg::IEX_MODE_LONG
                        || (s.mode == iex_pkg::IEX_MODE_PROT
                        && rpl != s.arch.current_priv_level))) begin
                        next_s.n = `IEX_POP_LONG; // [RL12]
                    end
                    if (s.idx + 3'h1 == next_s.n) begin
                        next_s.arch.instr_pointer = s.fr[0]; // [RL11]
                        next_s.arch.cs = s.fr[1][15:0];
                        next_s.arch.flags_word = (s.idx == 3'h2) ? v[31:0] : s.fr[2][31:0];
                        next_s.arch.wide_stack_pointer = fit(s.mode, s.maddr + w);
                        if (s.idx == 3'h4) begin
                            next_s.arch.wide_stack_pointer = s.fr[3]; // [RL12]
                            next_s.arch.ss = v[15:0];
                            if (s.mode == iex_pkg::IEX_MODE_PROT) begin
                                next_s.arch.current_priv_level = rpl;
                            end
                        end
                        next_s.st = iex_pkg::IEX_DONE;
                    end
                end
            end
            iex_pkg::IEX_DONE: begin
                next_s.st = iex_pkg::IEX_IDLE;
            end
            default: begin
                next_s.st = iex_pkg::IEX_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s <= '0;
            s.mode <= iex_pkg::iex_mode_e'(`IEX_CTRL_RST);
        end else begin
            s <= next_s;
        end
    end

    // =================================================================
    // Outputs
    assign o_avs_waitrequest = bus_req & ~s.ack;
    assign o_avs_readdata = s.rdata;
    assign o_req_ready = s.st == iex_pkg::IEX_IDLE;
    assign o_done = s.st == iex_pkg::IEX_DONE;
    assign o_fault = o_done & s.fault;
    assign o_arch = s.arch;
    assign o_tbl_valid = s.st == iex_pkg::IEX_LOOKUP;
    assign o_tbl_vector = s.vec;
    assign o_tbl_real = s.mode == iex_pkg::IEX_MODE_REAL;
    assign o_task_valid = s.st == iex_pkg::IEX_TASK;
    assign o_task_vector = s.vec;
    assign o_mem_valid = s.st == iex_pkg::IEX_PUSH || s.st == iex_pkg::IEX_POP;
    assign o_mem_write = s.st == iex_pkg::IEX_PUSH;
    assign o_mem_addr = s.maddr;
    assign o_mem_wdata = s.mdata;

    // =================================================================
    // Assertions
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    logic pushing;
    assign pushing = s.st == iex_pkg::IEX_PUSH && i_mem_ready;

    AST_INT_GATE_IF: assert property (s.st == iex_pkg::IEX_ENTER
        && s.gate.kind == iex_pkg::IEX_GATE_INTR |=> !o_arch.flags_word[`IEX_FLAG_IF]) // [RL5]
        else $error("interrupt gate entry left IF set");
    AST_TRAP_GATE_IF: assert property (s.st == iex_pkg::IEX_ENTER && s.mode != iex_pkg::IEX_MODE_REAL
        && s.gate.kind == iex_pkg::IEX_GATE_TRAP
        |=> $stable(o_arch.flags_word)) // [RL24]
        else $error("trap gate entry changed flags");
    AST_ENTRY_TARGET: assert property (s.st == iex_pkg::IEX_ENTER
        |=> o_done && o_arch.cs == $past(s.gate.cs) && o_arch.instr_pointer == $past(s.gate.ip)) // [RL4]
        else $error("handler target not loaded");
    AST_SAME_LEVEL_STACK: assert property (s.st == iex_pkg::IEX_LOOKUP && i_tbl_ready
        && s.mode == iex_pkg::IEX_MODE_PROT && i_gate.kind != iex_pkg::IEX_GATE_TASK
        && i_gate.dpl == s.arch.current_priv_level
        |=> s.arch.ss == $past(s.arch.ss) && !s.sw) // [RL1]
        else $error("stack switched at same level");
    AST_SWITCH_FIRST_PUSH: assert property (s.st == iex_pkg::IEX_LOOKUP && i_tbl_ready
        && s.mode == iex_pkg::IEX_MODE_PROT && i_gate.kind != iex_pkg::IEX_GATE_TASK
        && i_gate.dpl < s.arch.current_priv_level
        |=> o_mem_write && o_mem_wdata == {48'h0, $past(s.arch.ss)}
        && o_mem_addr == {32'h0, $past(i_gate.tss_sp[31:0]) - 32'h4}) // [RL7] [RL8]
        else $error("switching entry did not push old stack selector on new stack");
    AST_ERR_LAST: assert property (pushing && s.err && s.idx + 3'h1 == s.n
        |-> o_mem_wdata == fit(s.mode, {32'h0, s.ecode})) // [RL3] [RL9]
        else $error("error code not pushed last");
    AST_LONG_NULL_SS: assert property (s.st == iex_pkg::IEX_ENTER && s.sw
        && s.mode == iex_pkg::IEX_MODE_LONG |-> s.arch.ss == 16'h0) // [RL22]
        else $error("new stack selector not null on level change");
    AST_LONG_PUSH_COUNT: assert property (s.st == iex_pkg::IEX_PUSH && s.idx == 3'h0
        && s.mode == iex_pkg::IEX_MODE_LONG |-> s.n >= 3'h5) // [RL21] [RL22]
        else $error("long mode frame misses stack slots");
    AST_INTO_GATED: assert property (o_req_ready && i_req_valid && i_req.op == iex_pkg::IEX_OP_INTO
        && !i_arch.flags_word[`IEX_FLAG_OF] |=> o_done ##1 o_req_ready) // [RL17]
        else $error("overflow trap fired with flag clear");
    AST_BRKPT_VEC: assert property (o_req_ready && i_req_valid && i_req.op == iex_pkg::IEX_OP_INT3
        |=> o_tbl_valid && o_tbl_vector == `IEX_VEC_BRKPT) // [RL18]
        else $error("breakpoint not dispatched");
    AST_RANGE_VEC: assert property (o_req_ready && i_req_valid && i_req.op == iex_pkg::IEX_OP_BOUND
        |=> o_tbl_valid == $past(i_req.bound_out)) // [RL19]
        else $error("range check dispatch mismatch");
    AST_FP_VEC: assert property (o_req_ready && i_req_valid && i_req.op == iex_pkg::IEX_OP_FP
        && |i_req.fp_cond |=> o_tbl_vector
        == ($past(i_req.fp_simd) ? `IEX_VEC_SIMDFP : `IEX_VEC_FPERR)) // [RL20]
        else $error("fp exception routed to wrong vector");
    AST_INTR_RETURN_OP_FLAGS: assert property (s.st == iex_pkg::IEX_POP && i_mem_ready && s.idx == 3'h2
        && !next_s.fault && next_s.n == `IEX_POP_SHORT
        |=> o_done && o_arch.flags_word == $past(v[31:0])) // [RL10] [RL11]
        else $error("interrupt return did not reload flags");
endmodule : iex_exc_seq

// *** tb/iex_stack_model.sv ***
// Stack memory, lookup table and task unit model facing the sequencer
module iex_stack_model (
    // Clock and speed select
    input wire logic i_clk,
    input wire logic i_slow,
    // Sequencer requests
    input wire logic i_mem_valid,
    input wire logic i_mem_write,
    input wire logic [63:0] i_mem_addr,
    input wire logic [63:0] i_mem_wdata,
    input wire logic i_tbl_valid,
    input wire logic i_task_valid,
    // Answers
    output logic o_mem_ready,
    output logic [63:0] o_mem_rdata,
    output logic o_tbl_ready,
    output logic o_task_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] mem [0:16383];
    logic tgl = 1'b0;
    // Slow mode answers stack requests on every other cycle only
    always @(posedge i_clk) tgl <= ~tgl;
    assign o_mem_ready = i_mem_valid & (tgl | ~i_slow);
    assign o_tbl_ready = i_tbl_valid;
    assign o_task_done = i_task_valid & tgl;
    // Idle data lines churn so a stale word never passes for a pop
    assign o_mem_rdata = i_mem_valid ? mem[i_mem_addr[13:0]] : {32{tgl, ~tgl}};
    // Pushes land on the edge that completes the slot
    always @(posedge i_clk) begin
        if (o_mem_ready & i_mem_write) mem[i_mem_addr[13:0]] <= i_mem_wdata;
    end
endmodule : iex_stack_model

// *** tb/iex_exc_seq_tb.sv ***
// Self-checking bench for the exception entry and return sequencer
module iex_exc_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0, slow = 1'b0;
    logic i_req_valid = 1'b0, o_avs_waitrequest, o_req_ready, o_done, o_fault, o_tbl_valid;
    logic o_tbl_real, i_tbl_ready, o_task_valid, i_task_done, o_mem_valid, o_mem_write;
    logic i_mem_ready;
    logic [7:0] i_avs_address = 8'h00, o_tbl_vector, o_task_vector;
    logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, d;
    logic [63:0] o_mem_addr, o_mem_wdata, i_mem_rdata;
    iex_pkg::iex_req_s i_req = '0;
    iex_pkg::iex_arch_s i_arch = '0, o_arch, a;
    iex_pkg::iex_gate_s i_gate = '0;
    int n_fail = 0, checks = 0;
    always #5 i_clk = ~i_clk;
    iex_exc_seq iex_exc_seq_inst (.*);
    iex_stack_model iex_stack_model_inst (.i_clk(i_clk), .i_slow(slow),
        .i_mem_valid(o_mem_valid), .i_mem_write(o_mem_write), .i_mem_addr(o_mem_addr),
        .i_mem_wdata(o_mem_wdata), .i_tbl_valid(o_tbl_valid), .i_task_valid(o_task_valid),
        .o_mem_ready(i_mem_ready), .o_mem_rdata(i_mem_rdata), .o_tbl_ready(i_tbl_ready),
        .o_task_done(i_task_done));
    // ====
    // Bus and pipeline tasks
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Request holds until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge i_clk);
        {i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} <= {~w, w, ad, wd};
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        d = o_avs_readdata;
        {i_avs_read, i_avs_write} <= 2'b00;
    endtask : bus
    task automatic run(input iex_pkg::iex_op_e op, input logic [7:0] v, input logic [31:0] e);
        @(posedge i_clk);
        i_req_valid <= 1'b1;
        i_req <= '{op, v, e, 1'b0, 6'h00, 1'b0};
        i_arch <= a;
        @(posedge i_clk);
        i_req_valid <= 1'b0;
        do @(posedge i_clk); while (o_done !== 1'b1);
    endtask : run
    task automatic tally_and_finish;
        $display("Comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    // Watchdog: the whole sequence needs about a hundred cycles
    initial begin
        repeat (3000) @(posedge i_clk);
        n_fail++;
        tally_and_finish();
    end
    // ====
    // Test sequence
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b0, 8'h00, 32'h0);
        chk({64'h0, d}, 96'h1);
        bus(1'b0, 8'h0c, 32'h0);
        chk({64'h0, d}, 96'h0);
        $display("Register test done");
        a = '{32'h0a02, 16'h8, 64'h1000, 16'h10, 64'h2000, 2'h0};
        i_gate <= '{iex_pkg::IEX_GATE_INTR, 16'h18, 64'h4000, 2'h0, 16'h20, 64'h3000};
        run(iex_pkg::IEX_OP_INTN, 8'h21, 32'h0);
        chk(iex_stack_model_inst.mem[14'h1ffc], 96'h0a02);
        chk(iex_stack_model_inst.mem[14'h1ff4], 96'h1000);
        chk({o_arch.flags_word, o_arch.wide_stack_pointer}, {32'h0802, 64'h1ff4});
        chk({16'h0, o_arch.cs, o_arch.instr_pointer}, {32'h18, 64'h4000});
        // Slow stack while switching through a trap gate
        slow <= 1'b1;
        a = '{32'h0a02, 16'hb, 64'h1000, 16'h13, 64'h2000, 2'h3};
        i_gate <= '{iex_pkg::IEX_GATE_TRAP, 16'h18, 64'h4000, 2'h0, 16'h20, 64'h3000};
        run(iex_pkg::IEX_OP_EVENT, 8'h0d, 32'h5a);
        chk(iex_stack_model_inst.mem[14'h2ffc], 96'h13);
        chk(iex_stack_model_inst.mem[14'h2fec], 96'h1000);
        chk(iex_stack_model_inst.mem[14'h2fe8], 96'h5a);
        chk({o_arch.flags_word, o_arch.wide_stack_pointer}, {32'h0a02, 64'h2fe8});
        chk({78'h0, o_arch.ss, o_arch.current_priv_level}, {78'h0, 16'h20, 2'h0});
        a = '{32'h0, 16'h18, 64'h4000, 16'h20, 64'h2fec, 2'h0};
        run(iex_pkg::IEX_OP_INTR_RETURN_OP, 8'h00, 32'h0);
        chk(o_arch[81:0], {16'h13, 64'h2000, 2'h3});
        $display("Entry tests done");
        slow <= 1'b0;
        a = '{32'h0202, 16'h8, 64'h1000, 16'h10, 64'h2000, 2'h0};
        run(iex_pkg::IEX_OP_INTO, 8'h00, 32'h0);
        chk({32'h0, o_arch.instr_pointer}, 96'h1000);
        a.flags_word = 32'h0a02;
        run(iex_pkg::IEX_OP_INTO, 8'h00, 32'h0);
        bus(1'b0, 8'h04, 32'h0);
        chk({64'h0, d}, 96'h0400);
        bus(1'b0, 8'h08, 32'h0);
        chk({64'h0, d}, 96'h3);
        i_gate <= '{iex_pkg::IEX_GATE_TASK, 16'h18, 64'h4000, 2'h0, 16'h20, 64'h3000};
        run(iex_pkg::IEX_OP_INT3, 8'h00, 32'h0);
        chk({o_task_vector, o_arch.instr_pointer}, {8'h3, 64'h1000});
        // Return through the frame just pushed
        a = '{32'h0, 16'h18, 64'h4000, 16'h10, 64'h1ff4, 2'h0};
        run(iex_pkg::IEX_OP_INTR_RETURN_OP, 8'h00, 32'h0);
        chk({o_arch.flags_word, o_arch.instr_pointer}, {32'h0a02, 64'h1000});
        chk({16'h0, o_arch.cs, o_arch.wide_stack_pointer}, {32'h8, 64'h2000});
        a.current_priv_level = 2'h3;
        run(iex_pkg::IEX_OP_INTR_RETURN_OP, 8'h00, 32'h0);
        chk({o_fault, o_arch.instr_pointer}, {1'b1, 64'h4000});
        $display("Trap and return tests done");
        tally_and_finish();
    end
endmodule : iex_exc_seq_tb
